//--- core/opword_decoder_regs.svh
// Constants for the opword format decoder: field positions and opcode ranges.
// Assumes inclusion by each module file of the decoder; the package file does not include it.
`ifndef OPWORD_DECODER_REGS_SVH
`define OPWORD_DECODER_REGS_SVH
`define WORD_BITS 32
`define OPC_HI 31
`define OPC_LO 24
`define CTRL_OPC_MAX 8'h1f
`define CMPBR_OPC_MAX 8'h3f
`define REG_OPC_MAX 8'h7f
`define DST_HI 23
`define DST_LO 19
`define SRCB_HI 18
`define SRCB_LO 14
`define SRCA_HI 4
`define SRCA_LO 0
`define REG_M1_BIT 11
`define REG_M2_BIT 12
`define REG_M3_BIT 13
`define REG_SPEC1_BIT 5
`define REG_SPEC2_BIT 6
`define REG_SPEC3_BIT 7
`define CMPBR_M1_BIT 13
`define CMPBR_SPEC2_BIT 0
`define CMPBR_SRCA_HI 23
`define CMPBR_SRCA_LO 19
`define CMPBR_DISP_HI 12
`define CMPBR_DISP_LO 2
`define CMPBR_DISP_W 11
`define CTRL_DISP_HI 23
`define CTRL_DISP_LO 2
`define CTRL_DISP_W 22
`define DISP_SHIFT 2
`define MEM_LONG_BIT 12
`define SHORT_IDX_BIT 13
`define SHORT_OFF_HI 11
`define SHORT_OFF_LO 0
`define LONG_MODE_HI 13
`define LONG_MODE_LO 10
`define LONG_SCALE_HI 9
`define LONG_SCALE_LO 7
`define LONG_INDEX_HI 4
`define LONG_INDEX_LO 0
`define MODE_BASE 4'h0
`define MODE_IP_REL 4'h1
`define MODE_BASE_INDEX 4'h3
`define MODE_ABSOLUTE 4'h4
`define MODE_BASE_DISP 4'h5
`define MODE_INDEX_DISP 4'h6
`define MODE_BASE_INDEX_DISP 4'h7
`define LOCAL_BIT 4
`define IP_REL_BIAS 32'h0000_0008
`define WORD_BYTES 32'h0000_0004
`define LONG_INSN_BYTES 32'h0000_0008
`endif

//--- core/opword_decoder_pkg.sv
// Types shared by the opword format decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package opword_decoder_pkg;
  typedef enum logic [1:0] {
    operate_format, compare_branch_format, direct_branch_format, address_operand_format
  } format_e;
  typedef enum logic [1:0] {opnd_global, opnd_local, opnd_special, opnd_literal} opnd_kind_e;
  typedef enum logic [2:0] {
    ea_offset, ea_base_offset, ea_base, ea_ip_rel, ea_base_index, ea_index_disp,
    ea_base_index_disp, ea_absolute
  } ea_mode_e;
endpackage

//--- core/operand_kind_decoder.sv
// Classifies a 5-bit register operand field as global, local, special or literal.
// Assumes same-clock combinational use inside the decoder.
`timescale 1ns/100ps
`default_nettype none
`include "opword_decoder_regs.svh"
module operand_kind_decoder
  import opword_decoder_pkg::*;
(
  input wire logic [4:0] field,
  input wire logic literal_sel,
  input wire logic special_sel,
  input wire logic allow_literal,
  input wire logic allow_special,
  output opnd_kind_e kind,
  output logic legal
);
  // Pick the kind then check it against what the format allows
  always_comb begin
    if (literal_sel) begin
      kind = opnd_literal;
    end else if (special_sel) begin
      kind = opnd_special;
    end else if (field[`LOCAL_BIT]) begin
      kind = opnd_local;
    end else begin
      kind = opnd_global;
    end
    legal = !((literal_sel && !allow_literal) || (!literal_sel && special_sel && !allow_special));
  end
endmodule // operand_kind_decoder
`default_nettype wire

//--- core/effective_address_unit.sv
// Forms an effective address from decoded memory-format fields.
// Assumes register values are supplied by the pipeline on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "opword_decoder_regs.svh"
module effective_address_unit
  import opword_decoder_pkg::*;
(
  input wire ea_mode_e mode,
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_val,
  input wire logic [2:0] scale,
  input wire logic [31:0] disp,
  input wire logic [31:0] next_ip,
  output logic [31:0] ea
);
  logic [31:0] scaled;
  assign scaled = index_val << scale;
  // Sum the parts that the mode selects
  always_comb begin
    case (mode)
      ea_offset: ea = disp;
      ea_absolute: ea = disp;
      ea_base_offset: ea = base_val + disp;
      ea_base: ea = base_val;
      ea_ip_rel: ea = next_ip + disp + `IP_REL_BIAS;
      ea_base_index: ea = base_val + scaled;
      ea_index_disp: ea = scaled + disp;
      ea_base_index_disp: ea = base_val + scaled + disp;
      default: ea = disp;
    endcase
  end
endmodule // effective_address_unit
`default_nettype wire

//--- core/opword_format_decoder.sv
// Opword format decoder: classifies fetched words and extracts operand fields.
// Assumes the fetch unit presents aligned words with valid and the address.
`timescale 1ns/100ps
`default_nettype none
`include "opword_decoder_regs.svh"
module opword_format_decoder
  import opword_decoder_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_word,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_val,
  output logic dec_valid,
  output format_e format,
  output logic [7:0] opcode,
  output opnd_kind_e first_src_kind,
  output opnd_kind_e second_src_kind,
  output opnd_kind_e dst_kind,
  output logic [4:0] first_src_field,
  output logic [4:0] second_src_field,
  output logic [4:0] dst_field,
  output logic [31:0] disp,
  output logic long_enc,
  output ea_mode_e ea_mode,
  output logic [2:0] ea_scale,
  output logic [31:0] eff_addr,
  output logic [31:0] next_pc,
  output logic illegal
);
  // Opcode range to format, used by the decode and by the checks
  function automatic format_e fmt_of(input logic [7:0] op);
    if (op <= `CTRL_OPC_MAX) begin
      fmt_of = direct_branch_format;
    end else if (op <= `CMPBR_OPC_MAX) begin
      fmt_of = compare_branch_format;
    end else if (op <= `REG_OPC_MAX) begin
      fmt_of = operate_format;
    end else begin
      fmt_of = address_operand_format;
    end
  endfunction

  // Sign extension of a displacement field of a given width
  function automatic logic [31:0] sext(input logic [31:0] v, input int unsigned w);
    logic [31:0] m;
    m = 32'h0000_0001 << (w - 1);
    sext = (v ^ m) - m;
  endfunction

  typedef enum {st_opword, st_const} state_e;
  state_e state;
  logic [31:0] held_word;
  logic [31:0] held_addr;

  logic [31:0] w;
  logic [7:0] op;
  format_e fmt;
  logic is_long;
  ea_mode_e mode_c;
  logic [31:0] disp_c;
  logic [31:0] ea_c;
  opnd_kind_e k1, k2, kd;
  logic ok1, ok2, okd;
  logic lit1, lit2, lit_d, sp1, sp2, sp_d, al1, as1, al2, as2, ald, asd;
  logic [4:0] f1, f2, fd;
  logic emit;
  logic bad_mode;
  logic [31:0] ip_next;

  // Word under decode: held opword while its constant arrives
  assign w = (state == st_const) ? held_word : fetch_word;
  assign op = w[`OPC_HI:`OPC_LO];
  assign fmt = fmt_of(op);
  assign is_long = (fmt == address_operand_format) && w[`MEM_LONG_BIT];

  // Address after the instruction: one word, or two with its constant
  assign ip_next = (state == st_const) ? held_addr + `LONG_INSN_BYTES
                                       : fetch_addr + `WORD_BYTES;

  // Field selection per format
  always_comb begin
    lit1 = 1'b0;
    lit2 = 1'b0;
    lit_d = 1'b0;
    sp1 = 1'b0;
    sp2 = 1'b0;
    sp_d = 1'b0;
    al1 = 1'b0;
    as1 = 1'b0;
    al2 = 1'b0;
    as2 = 1'b0;
    ald = 1'b0;
    asd = 1'b0;
    f1 = w[`SRCA_HI:`SRCA_LO];
    f2 = w[`SRCB_HI:`SRCB_LO];
    fd = w[`DST_HI:`DST_LO];
    disp_c = 32'h0000_0000;
    mode_c = ea_offset;
    bad_mode = 1'b0;
    case (fmt)
      operate_format: begin
        lit1 = w[`REG_M1_BIT];
        lit2 = w[`REG_M2_BIT];
        lit_d = w[`REG_M3_BIT];
        sp1 = w[`REG_SPEC1_BIT];
        sp2 = w[`REG_SPEC2_BIT];
        sp_d = w[`REG_SPEC3_BIT];
        al1 = 1'b1;
        as1 = 1'b1;
        al2 = 1'b1;
        as2 = 1'b1;
        asd = 1'b1;
      end
      compare_branch_format: begin
        f1 = w[`CMPBR_SRCA_HI:`CMPBR_SRCA_LO];
        lit1 = w[`CMPBR_M1_BIT];
        sp2 = w[`CMPBR_SPEC2_BIT];
        al1 = 1'b1;
        as2 = 1'b1;
        disp_c = sext({21'h000000, w[`CMPBR_DISP_HI:`CMPBR_DISP_LO]}, `CMPBR_DISP_W)
                 << `DISP_SHIFT;
      end
      direct_branch_format: begin
        disp_c = sext({10'h000, w[`CTRL_DISP_HI:`CTRL_DISP_LO]}, `CTRL_DISP_W)
                 << `DISP_SHIFT;
      end
      default: begin
        f2 = w[`SRCB_HI:`SRCB_LO];
        f1 = w[`LONG_INDEX_HI:`LONG_INDEX_LO];
        if (is_long) begin
          disp_c = fetch_word;
          case (w[`LONG_MODE_HI:`LONG_MODE_LO])
            `MODE_BASE: mode_c = ea_base;
            `MODE_IP_REL: mode_c = ea_ip_rel;
            `MODE_BASE_INDEX: mode_c = ea_base_index;
            `MODE_ABSOLUTE: mode_c = ea_absolute;
            `MODE_BASE_DISP: mode_c = ea_base_offset;
            `MODE_INDEX_DISP: mode_c = ea_index_disp;
            `MODE_BASE_INDEX_DISP: mode_c = ea_base_index_disp;
            default: bad_mode = 1'b1;
          endcase
        end else begin
          disp_c = {20'h00000, w[`SHORT_OFF_HI:`SHORT_OFF_LO]};
          mode_c = w[`SHORT_IDX_BIT] ? ea_base_offset : ea_offset;
        end
      end
    endcase
  end

  operand_kind_decoder u_first (
    .field(f1), .literal_sel(lit1), .special_sel(sp1),
    .allow_literal(al1), .allow_special(as1), .kind(k1), .legal(ok1)
  );
  operand_kind_decoder u_second (
    .field(f2), .literal_sel(lit2), .special_sel(sp2),
    .allow_literal(al2), .allow_special(as2), .kind(k2), .legal(ok2)
  );
  operand_kind_decoder u_dst (
    .field(fd), .literal_sel(lit_d), .special_sel(sp_d),
    .allow_literal(ald), .allow_special(asd), .kind(kd), .legal(okd)
  ); // via ald and asd low for address format

  effective_address_unit u_ea (
    .mode(mode_c), .base_val(base_val), .index_val(index_val),
    .scale(w[`LONG_SCALE_HI:`LONG_SCALE_LO]), .disp(disp_c),
    .next_ip(ip_next),
    .ea(ea_c)
  );

  // A decode is emitted on a plain opword or when the constant arrives
  assign emit = ce && fetch_valid && (state == st_const || !is_long);

  // Two-word sequencing for long constant encoding
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= st_opword;
      held_word <= 32'h0000_0000;
      held_addr <= 32'h0000_0000;
    end else if (ce && fetch_valid) begin
      if (state == st_opword && is_long) begin
        state <= st_const;
        held_word <= fetch_word;
        held_addr <= fetch_addr;
      end else begin
        state <= st_opword;
      end
    end
  end

  // Registered decode outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dec_valid <= 1'b0;
      format <= operate_format;
      opcode <= 8'h00;
      first_src_kind <= opnd_global;
      second_src_kind <= opnd_global;
      dst_kind <= opnd_global;
      first_src_field <= 5'h00;
      second_src_field <= 5'h00;
      dst_field <= 5'h00;
      disp <= 32'h0000_0000;
      long_enc <= 1'b0;
      ea_mode <= ea_offset;
      ea_scale <= 3'h0;
      eff_addr <= 32'h0000_0000;
      next_pc <= 32'h0000_0000;
      illegal <= 1'b0;
    end else if (ce) begin
      dec_valid <= emit;
      if (emit) begin
        format <= fmt;
        opcode <= op;
        first_src_kind <= k1;
        second_src_kind <= k2;
        dst_kind <= kd;
        first_src_field <= f1;
        second_src_field <= f2;
        dst_field <= fd;
        disp <= disp_c;
        long_enc <= is_long;
        ea_mode <= mode_c;
        ea_scale <= w[`LONG_SCALE_HI:`LONG_SCALE_LO];
        eff_addr <= ea_c;
        next_pc <= ip_next;
        illegal <= !(ok1 && ok2 && okd) || bad_mode;
      end
    end
  end

  // Assertions
  a_format_matches_op: assert property (@(posedge clk) disable iff (!nrst)
    dec_valid |-> format == fmt_of(opcode)) else $error("format not from opcode");
  a_opcode_top_byte: assert property (@(posedge clk) disable iff (!nrst)
    (ce && fetch_valid && state == st_opword && !is_long) |=> opcode == $past(fetch_word[31:24]))
    else $error("opcode not top byte");
  sequence s_long_op;
    ce && fetch_valid && state == st_opword && is_long;
  endsequence
  sequence s_const_word;
    ce && fetch_valid;
  endsequence
  a_long_two_words: assert property (@(posedge clk) disable iff (!nrst)
    s_long_op ##1 s_const_word |=> dec_valid && long_enc && disp == $past(fetch_word))
    else $error("long constant not consumed");
  a_long_no_early: assert property (@(posedge clk) disable iff (!nrst)
    s_long_op |=> !dec_valid) else $error("long opword emitted early");
  a_long_pc_two: assert property (@(posedge clk) disable iff (!nrst)
    s_long_op ##1 s_const_word |=> next_pc == $past(held_addr) + `LONG_INSN_BYTES)
    else $error("long pc wrong");
  a_single_word_pc: assert property (@(posedge clk) disable iff (!nrst)
    (ce && fetch_valid && state == st_opword && !is_long)
      |=> next_pc == $past(fetch_addr) + `WORD_BYTES)
    else $error("pc not one word on");
  a_short_ea_mode: assert property (@(posedge clk) disable iff (!nrst)
    (ce && fetch_valid && state == st_opword && fmt == address_operand_format && !is_long)
      |=> ea_mode inside {ea_offset, ea_base_offset})
    else $error("short mode wrong");
  a_operate_dst_reg: assert property (@(posedge clk) disable iff (!nrst)
    (dec_valid && format == operate_format && !illegal) |-> dst_kind != opnd_literal)
    else $error("operate dst literal");
  a_cmpbr_first_kind: assert property (@(posedge clk) disable iff (!nrst)
    (dec_valid && format == compare_branch_format) |-> first_src_kind != opnd_special)
    else $error("compare first source special");
  a_cmpbr_second_kind: assert property (@(posedge clk) disable iff (!nrst)
    (dec_valid && format == compare_branch_format) |-> second_src_kind != opnd_literal)
    else $error("compare second source literal");
  a_mem_dst_kind: assert property (@(posedge clk) disable iff (!nrst)
    (dec_valid && format == address_operand_format && !illegal)
      |-> dst_kind inside {opnd_global, opnd_local}) else $error("mem dst bad");
  a_index_disp_long: assert property (@(posedge clk) disable iff (!nrst)
    (dec_valid && ea_mode == ea_base_index_disp) |-> long_enc)
    else $error("scaled index short");
  a_ip_rel_bias: assert property (@(posedge clk) disable iff (!nrst)
    (dec_valid && ea_mode == ea_ip_rel) |-> eff_addr == next_pc + disp + `IP_REL_BIAS)
    else $error("ip relative wrong");
endmodule // opword_format_decoder
`default_nettype wire

//--- testbench/fetch_feed.sv
// Fetch-side model: offers queued words to the decoder, promptly or with gaps.
// Assumes the bench pushes words and their byte addresses in program order.
`timescale 1ns/100ps
`default_nettype none
module fetch_feed (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic slow,
  output logic fetch_valid,
  output logic [31:0] fetch_word,
  output logic [31:0] fetch_addr
);
  logic [31:0] wq[$];
  logic [31:0] aq[$];
  logic [7:0] gap = 8'h5a;

  // Idle values at time zero
  initial begin
    fetch_valid = 1'b0;
    fetch_word = 32'h0;
    fetch_addr = 32'h0;
  end

  // Queue one word; low address bits forced clear
  task automatic push(input logic [31:0] w, input logic [31:0] a);
    wq.push_back(w);
    aq.push_back({a[31:2], 2'h0});
  endtask

  // Hold a word until taken; idle lines toggle so stale data never matches
  always @(posedge clk) begin
    gap <= {gap[6:0], gap[7] ^ gap[5] ^ gap[4] ^ gap[3]};
    if (!nrst) begin
      fetch_valid <= 1'b0;
    end else if (!fetch_valid || ce) begin
      if (wq.size() > 0 && !(slow && gap[0])) begin
        fetch_valid <= 1'b1;
        fetch_word <= wq.pop_front();
        fetch_addr <= aq.pop_front();
      end else begin
        fetch_valid <= 1'b0;
        fetch_word <= ~fetch_word;
        fetch_addr <= ~fetch_addr;
      end
    end
  end
endmodule // fetch_feed
`default_nettype wire

//--- testbench/opword_format_decoder_tb.sv
// Self-checking bench for the opword decoder with a reference model.
// Assumes fetch_feed as the fetch side; register values are random.
`timescale 1ns/100ps
`default_nettype none
module opword_format_decoder_tb
  import opword_decoder_pkg::*;
;
  logic clk, nrst, slow, ce_rand;
  logic ce = 1'b1;
  logic [31:0] bv, iv;
  logic [31:0] base_val, index_val, next_pc, disp, eff_addr, pc;
  logic fetch_valid, dec_valid, long_enc, illegal;
  logic [31:0] fetch_word, fetch_addr;
  format_e format;
  logic [7:0] opcode;
  opnd_kind_e first_src_kind, second_src_kind, dst_kind;
  logic [4:0] first_src_field, second_src_field, dst_field;
  ea_mode_e ea_mode;
  logic [2:0] ea_scale;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h0000_001f;
  logic take, rst_seen, cen;
  logic pend = 1'b0;
  logic [31:0] w, a, ow, oa;
  logic [7:0] edges [8] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hff};

  opword_format_decoder DUT (.clk(clk), .nrst(nrst), .ce(ce), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_addr(fetch_addr), .base_val(base_val),
    .index_val(index_val), .dec_valid(dec_valid), .format(format), .opcode(opcode),
    .first_src_kind(first_src_kind), .second_src_kind(second_src_kind), .dst_kind(dst_kind),
    .first_src_field(first_src_field), .second_src_field(second_src_field),
    .dst_field(dst_field), .disp(disp),
    .long_enc(long_enc), .ea_mode(ea_mode), .ea_scale(ea_scale), .eff_addr(eff_addr),
    .next_pc(next_pc), .illegal(illegal));
  fetch_feed feed (.clk(clk), .nrst(nrst), .ce(ce), .slow(slow), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_addr(fetch_addr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic format_e fmt_of(input logic [7:0] o);
    if (o <= 8'h1f) return direct_branch_format;
    if (o <= 8'h3f) return compare_branch_format;
    if (o <= 8'h7f) return operate_format;
    return address_operand_format;
  endfunction

  function automatic opnd_kind_e kind(input logic lit, input logic special_function_register, input logic loc);
    if (lit) return opnd_literal;
    if (special_function_register) return opnd_special;
    return loc ? opnd_local : opnd_global;
  endfunction

  // Long addressing modes and their effective addresses
  function automatic ea_mode_e exp_mode(input logic [3:0] m);
    case (m)
      4'h0: return ea_base;
      4'h1: return ea_ip_rel;
      4'h3: return ea_base_index;
      4'h4: return ea_absolute;
      4'h5: return ea_base_offset;
      4'h6: return ea_index_disp;
      4'h7: return ea_base_index_disp;
      default: return ea_offset;
    endcase
  endfunction

  function automatic logic [31:0] exp_ea(input logic [3:0] m, input logic [2:0] s,
                                         input logic [31:0] ad, input logic [31:0] c);
    logic [31:0] sc;
    sc = iv << s;
    case (m)
      4'h0: return bv;
      4'h1: return ad + 32'h8 + c + 32'h8;
      4'h3: return bv + sc;
      4'h4: return c;
      4'h5: return bv + c;
      4'h6: return sc + c;
      4'h7: return bv + sc + c;
      default: return c;
    endcase
  endfunction

  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Queue a word; a long memory opword is followed by its constant word
  task automatic put(input logic [31:0] x);
    if (x[31:24] inside {[8'h40:8'h7f]}) begin
      if (x[11]) x[5] = 1'b0;
      if (x[12]) x[6] = 1'b0;
      if (x[13]) x[7] = 1'b0;
    end
    feed.push(x, pc);
    pc += 32'h4;
    if (x[31] && x[12]) begin
      feed.push(rnd(), pc);
      pc += 32'h4;
    end
  endtask

  task automatic drain();
    for (int n = 0; n < 5000 && (feed.wq.size() > 0 || fetch_valid); n++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  // Expected outputs for one decoded instruction
  task automatic check_out(input logic [31:0] x, input logic [31:0] ad, input logic [31:0] c,
                           input logic l);
    chk(dec_valid, 1);
    chk(opcode, x[31:24]);
    chk(format, fmt_of(x[31:24]));
    chk(next_pc, ad + (l ? 32'h8 : 32'h4));
    case (fmt_of(x[31:24]))
      operate_format: begin
        chk({first_src_field, second_src_field, dst_field}, {x[4:0], x[18:14], x[23:19]});
        chk(first_src_kind, kind(x[11], x[5], x[4]));
        chk(second_src_kind, kind(x[12], x[6], x[18]));
        if (!x[13]) chk(dst_kind, kind(1'b0, x[7], x[23]));
        chk(illegal, x[13]);
      end
      compare_branch_format: begin
        chk({first_src_field, second_src_field}, {x[23:19], x[18:14]});
        chk(first_src_kind, kind(x[13], 1'b0, x[23]));
        chk(second_src_kind, kind(1'b0, x[0], x[18]));
        chk(disp, {{19{x[12]}}, x[12:2], 2'h0});
        chk(illegal, 0);
      end
      direct_branch_format: begin
        chk(disp, {{8{x[23]}}, x[23:2], 2'h0});
        chk(illegal, 0);
      end
      default: begin
        chk(long_enc, l);
        chk(dst_kind, kind(1'b0, 1'b0, x[23]));
        chk(dst_field, x[23:19]);
        if (l) begin
          chk(disp, c);
          chk(ea_scale, x[9:7]);
          chk(ea_mode, exp_mode(x[13:10]));
          chk(eff_addr, exp_ea(x[13:10], x[9:7], ad, c));
          chk(illegal, x[13:10] == 4'h2 || x[13]);
        end else begin
          chk(disp, {20'h0, x[11:0]});
          chk(ea_mode, x[13] ? ea_base_offset : ea_offset);
          chk(eff_addr, (x[13] ? bv : 32'h0) + {20'h0, x[11:0]});
          chk(illegal, 0);
        end
      end
    endcase
  endtask

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Reference monitor: sample taken words at each edge, check the registered outputs 1 ns later
  always @(posedge clk) begin
    take = nrst && ce && fetch_valid;
    rst_seen = !nrst;
    cen = ce;
    w = fetch_word;
    a = fetch_addr;
    bv = base_val;
    iv = index_val;
    #1;
    if (rst_seen) begin
      pend = 1'b0;
      chk({dec_valid, format, next_pc}, 0);
    end else if (cen) begin
      if (take && pend) begin
        pend = 1'b0;
        check_out(ow, oa, w, 1'b1);
      end else if (take && w[31] && w[12]) begin
        pend = 1'b1;
        ow = w;
        oa = a;
        chk(dec_valid, 0);
      end else if (take) check_out(w, a, 32'h0, 1'b0);
      else chk(dec_valid, 0);
    end
  end

  // Random register values and clock-enable gaps
  always @(posedge clk) begin
    base_val <= rnd();
    index_val <= rnd();
    ce <= ce_rand ? ((rnd() & 32'h7) != 32'h0) : 1'b1;
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    slow = 1'b0;
    ce_rand = 1'b0;
    pc = 32'h0000_1000;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    foreach (edges[i]) put((rnd() & 32'h00ff_ffff) | {edges[i], 24'h000000});
    drain();
    slow <= 1'b1;
    ce_rand <= 1'b1;
    repeat (400) put(rnd());
    drain();
    ce_rand <= 1'b0;
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    slow <= 1'b0;
    repeat (40) put(rnd() | 32'h8000_1000);
    repeat (8) put((rnd() & 32'hffff_c3ff) | 32'h8000_1400);
    drain();
    end_sim();
  end
endmodule // opword_format_decoder_tb
`default_nettype wire
